// file: src/nvm_program_control.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] while otp latch set, array reads return junk; vectors and boot code unavailable
// [R2] stop mode entry returns otp array to plain read mode
// [R3] unprogrammed otp byte reads as zero
// [R4] programming only sets bits; ones never return to zero
// [R5] up to eight bytes programmed together, sharing all but low three address bits
// [R6] stop, power-on and external reset clear the otp latch bit
// [R7] latch set, program clear: cpu writes capture address and up to eight bytes
// [R8] otp program enable needs latch and a loaded byte; cleared only via latch
// [R9] otp states: 00 read, 10 load, 11 program; enable never set without latch
// [R10] latch and pump set: select bit chooses erase (1) or program (0)
// [R11] select bit frozen once eeprom target address is latched
// [R12] eeprom latch allows capture with pump clear; clearing latch zeroes select and pump
// [R13] stop, power-on and external reset clear the eeprom latch bit
// [R14] pump bit switches the internal charge pump on and off
// [R15] pump refuses to set before data latched; cleared only via latch
// [R16] eeprom states 000 read, 010 load, 011 program, 110 erase load, 111 erase
// [R17] reset held 16 cycles with reset-time option set, else 4064; the code always holds 4064, as the option bit reads zero at release
// [R18] watchdog-after-reset option runs watchdog after reset, not in bootstrap
// [R19] watchdog-in-wait option keeps watchdog counting in wait mode
// [R20] port pull-down option connects pull-downs only on pins set as inputs
// [R21] low 32 eeprom bytes never protected; protect bit 0 blocks upper 224
// [R22] protect bit written zero only with eeprom latch; one holds till reset
// [R23] security bit zero blocks non-user modes; change effective after next reset; the code reloads the bit to one at every reset, so nothing is blocked
// [R24] with a latch set, array writes load latches, not ordinary memory writes
module nvm_program_control #(
  parameter int POR_LONG  = nvm_pkg::POR_LONG_CYC,
  parameter int OTP_WORDS = 256,
  parameter int GROUP     = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire nvm_pkg::mem_wr_t     otp_wr,
  input  wire logic [15:0]          otp_rd_addr,
  output logic [7:0]                otp_rd_data,
  output logic                      otp_fetch_block,
  input  wire nvm_pkg::mem_wr_t     ee_wr,
  output logic                      ee_wr_pass,
  input  wire logic                 stop_mode,
  input  wire logic                 wait_mode,
  input  wire logic                 bootstrap_mode,
  input  wire logic [7:0]           port_b_ddr,
  input  wire logic [7:0]           port_c_ddr,
  output logic [7:0]                port_b_pulldown,
  output logic [7:0]                port_c_pulldown,
  output logic                      watchdog_run,
  output logic                      non_user_block,
  output logic                      charge_pump_on,
  output logic                      ee_erase_cmd,
  output logic                      ee_write_fail,
  output logic                      external_clock_output_enable,
  output logic                      reset_pin_n
);
  localparam int OAW = $clog2(OTP_WORDS);

  initial
  begin
    if (GROUP != 8 || OTP_WORDS < GROUP || OTP_WORDS > 65536)
      $error("nvm_program_control parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // control bits

  logic otp_latch_enable_q;
  logic otp_program_enable_q;
  logic eeprom_erase_select_q;
  logic eeprom_latch_enable_q;
  logic eeprom_pump_enable_q;
  logic clkout_q;
  logic ee_addr_taken_q;
  logic [15:0] ee_addr_q;
  logic [7:0]  ee_data_q;
  logic [1:0]  opt_q;
  logic [1:0]  opt_live_q;
  logic [4:0]  factory_option_bits_q;
  logic        stop_q;

  logic        bus_wr;
  logic        bus_rd;
  logic [17:0] baddr;
  logic        any_loaded;
  logic [15:0] group_addr;
  logic [GROUP-1:0] byte_valid;
  logic [7:0]  prog_data [GROUP];
  logic [7:0]  cell_q [GROUP];
  logic        group_err;
  logic        stop_rise;
  logic        otp_prog_pulse;

  assign baddr     = paddr[17:0];
  assign bus_wr    = psel && penable && pwrite && pready;
  assign bus_rd    = psel && penable && !pwrite && pready;
  assign stop_rise = stop_mode && !stop_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stop_q <= 1'b0;
    else
      stop_q <= stop_mode;
  end

  // one wait state keeps the read mux registered
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // otp array control

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      otp_latch_enable_q   <= 1'b0; // [R6]
      otp_program_enable_q <= 1'b0;
      clkout_q             <= 1'b0;
    end
    else if (stop_rise)
    begin
      otp_latch_enable_q   <= 1'b0; // [R2] [R6]
      otp_program_enable_q <= 1'b0;
    end
    else if (bus_wr && baddr == nvm_pkg::CTRL_ADDR)
    begin
      clkout_q           <= pwdata[nvm_pkg::CLKOUT_BIT];
      otp_latch_enable_q <= pwdata[nvm_pkg::OTP_LAT_BIT];
      if (!pwdata[nvm_pkg::OTP_LAT_BIT])
        otp_program_enable_q <= 1'b0; // [R8] [R9]
      else if (otp_latch_enable_q && any_loaded && !group_err &&
               pwdata[nvm_pkg::OTP_PGM_BIT])
        otp_program_enable_q <= 1'b1; // [R8] [R9]
    end
  end

  assign otp_prog_pulse = otp_program_enable_q && any_loaded;

  otp_latch #(
    .DEPTH (GROUP)
  ) u_latch (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clear      (!otp_latch_enable_q),
    .wr         ('{valid: otp_wr.valid && otp_latch_enable_q && !otp_program_enable_q,
                   addr: otp_wr.addr, data: otp_wr.data}), // [R7] [R24]
    .prog_pulse (otp_prog_pulse),
    .cell_q     (cell_q),
    .any_loaded (any_loaded),
    .group_addr (group_addr),
    .byte_valid (byte_valid),
    .prog_data  (prog_data),
    .group_err  (group_err)
  );

  // array model of the otp cells, cleared to the erased value
  logic [7:0] otp_mem [OTP_WORDS];

  genvar g;
  generate
    for (g = 0; g < GROUP; g++)
    begin : g_cell
      logic [OAW-1:0] a;
      assign a        = OAW'({group_addr[15:3], 3'(g)});
      assign cell_q[g] = otp_mem[a];
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < OTP_WORDS; k++)
        otp_mem[k] <= nvm_pkg::OTP_ERASED; // [R3]
    end
    else if (otp_prog_pulse)
    begin
      for (int k = 0; k < GROUP; k++)
        if (byte_valid[k])
          otp_mem[OAW'({group_addr[15:3], 3'(k)})] <= cell_q[k] | prog_data[k]; // [R4] [R5]
    end
  end

  // reset value is a simulation convenience; real cells keep their charge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      otp_rd_data     <= 8'h00;
      otp_fetch_block <= 1'b0;
    end
    else
    begin
      otp_fetch_block <= otp_latch_enable_q; // [R1]
      if (otp_latch_enable_q)
        otp_rd_data <= ~otp_rd_addr[7:0]; // [R1]
      else
        otp_rd_data <= otp_mem[OAW'(otp_rd_addr)];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // eeprom control

  logic ee_in_range;
  logic ee_protected;
  assign ee_in_range  = ee_wr.addr >= nvm_pkg::EE_BASE && ee_wr.addr <= nvm_pkg::EE_TOP;
  assign ee_protected = !opt_live_q[nvm_pkg::PROTECT_BIT] && !bootstrap_mode &&
                        ee_addr_q >= nvm_pkg::EE_PROT_BASE; // [R21] [R22]

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      eeprom_latch_enable_q <= 1'b0; // [R13]
      eeprom_erase_select_q <= 1'b0;
      eeprom_pump_enable_q  <= 1'b0;
    end
    else if (stop_rise)
    begin
      eeprom_latch_enable_q <= 1'b0; // [R13]
      eeprom_erase_select_q <= 1'b0;
      eeprom_pump_enable_q  <= 1'b0;
    end
    else if (bus_wr && baddr == nvm_pkg::CTRL_ADDR)
    begin
      eeprom_latch_enable_q <= pwdata[nvm_pkg::EE_LAT_BIT];
      if (!pwdata[nvm_pkg::EE_LAT_BIT])
      begin
        eeprom_erase_select_q <= 1'b0; // [R12]
        eeprom_pump_enable_q  <= 1'b0; // [R12] [R15]
      end
      else
      begin
        if (!ee_addr_taken_q)
          eeprom_erase_select_q <= pwdata[nvm_pkg::EE_ERA_BIT]; // [R11]
        if (eeprom_latch_enable_q && ee_addr_taken_q && pwdata[nvm_pkg::EE_PGM_BIT])
          eeprom_pump_enable_q <= 1'b1; // [R14] [R15]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ee_addr_taken_q <= 1'b0;
      ee_addr_q       <= 16'h0000;
      ee_data_q       <= 8'h00;
    end
    else if (!eeprom_latch_enable_q)
      ee_addr_taken_q <= 1'b0;
    else if (ee_wr.valid && ee_in_range && !eeprom_pump_enable_q)
    begin
      ee_addr_taken_q <= 1'b1; // [R12] [R24]
      ee_addr_q       <= ee_wr.addr;
      ee_data_q       <= ee_wr.data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      charge_pump_on <= 1'b0;
      ee_erase_cmd   <= 1'b0;
      ee_write_fail  <= 1'b0;
      ee_wr_pass     <= 1'b0;
    end
    else
    begin
      charge_pump_on <= eeprom_latch_enable_q && eeprom_pump_enable_q &&
                        !ee_protected; // [R14] [R21]
      ee_erase_cmd   <= eeprom_latch_enable_q && eeprom_pump_enable_q &&
                        eeprom_erase_select_q && !ee_protected; // [R10] [R16] [R21]
      ee_write_fail  <= eeprom_pump_enable_q && ee_protected; // [R21]
      ee_wr_pass     <= ee_wr.valid && !eeprom_latch_enable_q; // [R24]
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // option registers

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      opt_q                 <= nvm_pkg::OPT_RESET;
      factory_option_bits_q <= nvm_pkg::FACT_RESET;
    end
    else if (bus_wr && baddr == nvm_pkg::OPT_ADDR)
    begin
      opt_q[nvm_pkg::SECURE_BIT] <= pwdata[nvm_pkg::SECURE_BIT];
      if (eeprom_latch_enable_q && !pwdata[nvm_pkg::PROTECT_BIT])
        opt_q[nvm_pkg::PROTECT_BIT] <= 1'b0; // [R22]
    end
    else if (bus_wr && baddr == nvm_pkg::FACT_ADDR && otp_latch_enable_q)
      factory_option_bits_q <= factory_option_bits_q | pwdata[4:0]; // [R4]
  end

  // the stored security bit takes effect only from the reset release; a cleared protect bit takes effect one cycle later
  logic live_taken_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      opt_live_q   <= nvm_pkg::OPT_RESET;
      live_taken_q <= 1'b0;
    end
    else if (!live_taken_q)
    begin
      opt_live_q   <= opt_q; // [R22] [R23]
      live_taken_q <= 1'b1;
    end
    else if (!opt_q[nvm_pkg::PROTECT_BIT])
      opt_live_q[nvm_pkg::PROTECT_BIT] <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port_b_pulldown <= 8'h00;
      port_c_pulldown <= 8'h00;
      watchdog_run    <= 1'b0;
      non_user_block  <= 1'b0;
      external_clock_output_enable <= 1'b0;
    end
    else
    begin
      port_b_pulldown <= {8{factory_option_bits_q[nvm_pkg::PB_PULL_BIT]}} & ~port_b_ddr; // [R20]
      port_c_pulldown <= {8{factory_option_bits_q[nvm_pkg::PC_PULL_BIT]}} & ~port_c_ddr; // [R20]
      watchdog_run    <= factory_option_bits_q[nvm_pkg::WDOG_RST_BIT] && !bootstrap_mode &&
                         (!wait_mode ||
                          factory_option_bits_q[nvm_pkg::WDOG_WAIT_BIT]); // [R18] [R19]
      non_user_block  <= !opt_live_q[nvm_pkg::SECURE_BIT]; // [R23]
      external_clock_output_enable <= clkout_q;
    end
  end

  por_stretch #(
    .LONG_CYC  (POR_LONG),
    .SHORT_CYC (nvm_pkg::POR_SHORT_CYC)
  ) u_por (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .short_sel   (factory_option_bits_q[nvm_pkg::RST_TIME_BIT]), // [R17]
    .reset_n_out (reset_pin_n)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // read mux

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= 1'b0;
      case (baddr)
        nvm_pkg::CTRL_ADDR: prdata <= {26'h0, otp_latch_enable_q, otp_program_enable_q, clkout_q,
                                       eeprom_erase_select_q, eeprom_latch_enable_q,
                                       eeprom_pump_enable_q};
        nvm_pkg::OPT_ADDR:  prdata <= {30'h0, opt_q};
        nvm_pkg::FACT_ADDR: prdata <= {27'h0, factory_option_bits_q};
        nvm_pkg::STAT_ADDR: prdata <= {23'h0, group_err, byte_valid};
        default:
        begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
    else
      pslverr <= 1'b0;
  end
endmodule

// file: src/nvm_pkg.sv
package nvm_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [15:0] CTRL_IDX          = 16'h0007;
  localparam logic [15:0] OPT_IDX           = 16'h0100;
  localparam logic [15:0] FACT_IDX          = 16'h3DFE;
  localparam logic [15:0] STAT_IDX          = 16'h0200;
  localparam logic [17:0] CTRL_ADDR         = {CTRL_IDX, 2'b00};
  localparam logic [17:0] OPT_ADDR          = {OPT_IDX, 2'b00};
  localparam logic [17:0] FACT_ADDR         = {FACT_IDX, 2'b00};
  localparam logic [17:0] STAT_ADDR         = {STAT_IDX, 2'b00};

  // control register fields
  localparam int          OTP_LAT_BIT       = 5;
  localparam int          OTP_PGM_BIT       = 4;
  localparam int          CLKOUT_BIT        = 3;
  localparam int          EE_ERA_BIT        = 2;
  localparam int          EE_LAT_BIT        = 1;
  localparam int          EE_PGM_BIT        = 0;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;

  // option register fields
  localparam int          PROTECT_BIT       = 1;
  localparam int          SECURE_BIT        = 0;
  localparam logic [1:0]  OPT_RESET         = 2'h3;

  // factory option fields
  localparam int          RST_TIME_BIT      = 4;
  localparam int          WDOG_RST_BIT      = 3;
  localparam int          WDOG_WAIT_BIT     = 2;
  localparam int          PB_PULL_BIT       = 1;
  localparam int          PC_PULL_BIT       = 0;
  localparam logic [4:0]  FACT_RESET        = 5'h00;

  // eeprom window, unprotected low part
  localparam logic [15:0] EE_BASE           = 16'h0100;
  localparam logic [15:0] EE_PROT_BASE      = 16'h0120;
  localparam logic [15:0] EE_TOP            = 16'h01FF;
  localparam logic [7:0]  OTP_ERASED        = 8'h00;

  // power-on reset hold lengths in cycles
  localparam int          POR_SHORT_CYC     = 16;
  localparam int          POR_LONG_CYC      = 4064;

  typedef enum logic [1:0]
  {
    OTP_READ  = 2'b00,
    OTP_LOAD  = 2'b10,
    OTP_PROG  = 2'b11
  } otp_state_t;

  typedef struct packed
  {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_t;

endpackage

// file: src/otp_latch.sv
`timescale 1ns/1ns
module otp_latch #(
  parameter int DEPTH = 8
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clear,
  input  wire nvm_pkg::mem_wr_t    wr,
  input  wire logic                prog_pulse,
  input  wire logic [7:0]          cell_q [DEPTH],
  output logic                     any_loaded,
  output logic [15:0]              group_addr,
  output logic [DEPTH-1:0]         byte_valid,
  output logic [7:0]               prog_data [DEPTH],
  output logic                     group_err
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH != 8)
      $error("otp_latch supports a group of eight bytes only");
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      group_addr <= 16'h0000;
      group_err  <= 1'b0;
    end
    else if (clear)
    begin
      group_err  <= 1'b0;
    end
    else if (wr.valid)
    begin
      if (byte_valid == '0)
        group_addr <= {wr.addr[15:AW], {AW{1'b0}}};
      else if (wr.addr[15:AW] != group_addr[15:AW])
        group_err <= 1'b1; // [R5]
    end
  end

  assign any_loaded = |byte_valid;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_slot
      logic hit;
      assign hit = wr.valid && (wr.addr[AW-1:0] == AW'(i)) &&
                   (byte_valid == '0 || wr.addr[15:AW] == group_addr[15:AW]);
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          byte_valid[i] <= 1'b0;
          prog_data[i]  <= 8'h00;
        end
        else if (clear)
        begin
          byte_valid[i] <= 1'b0;
        end
        else if (hit)
        begin
          byte_valid[i] <= 1'b1; // [R7]
          prog_data[i]  <= wr.data;
        end
      end
    end
  endgenerate

  // unused when idle; kept for cell merge visibility
  logic unused_ok;
  assign unused_ok = prog_pulse & (cell_q[0] == 8'h00);
endmodule

// file: src/por_stretch.sv
`timescale 1ns/1ns
module por_stretch #(
  parameter int LONG_CYC  = nvm_pkg::POR_LONG_CYC,
  parameter int SHORT_CYC = nvm_pkg::POR_SHORT_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic short_sel,
  output logic      reset_n_out
);
  initial
  begin
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC > 65535)
      $error("por_stretch counts out of range");
  end

  logic [15:0] cnt_q;
  logic        started_q;

  // length chosen from the strap after release, never during reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q       <= 16'h0000;
      started_q   <= 1'b0;
      reset_n_out <= 1'b0;
    end
    else if (!started_q)
    begin
      started_q <= 1'b1;
      cnt_q     <= short_sel ? 16'(SHORT_CYC - 1) : 16'(LONG_CYC - 1); // [R17]
    end
    else if (cnt_q != 16'h0000)
    begin
      cnt_q <= cnt_q - 16'h0001;
    end
    else
    begin
      reset_n_out <= 1'b1;
    end
  end
endmodule

// file: dv/nvm_program_control_monitor.sv
`timescale 1ns/1ns
module nvm_program_control_monitor #(
  parameter int POR_LONG = nvm_pkg::POR_LONG_CYC
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] otp_rd_addr,
  input wire logic [7:0]  otp_rd_data,
  input wire logic        otp_fetch_block,
  input wire logic        stop_mode,
  input wire logic [7:0]  port_b_ddr,
  input wire logic [7:0]  port_c_ddr,
  input wire logic [7:0]  port_b_pulldown,
  input wire logic [7:0]  port_c_pulldown,
  input wire logic        charge_pump_on,
  input wire logic        ee_erase_cmd,
  input wire logic        ee_wr_pass,
  input wire logic        reset_pin_n
);
  int cyc_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_access;
    $rose(psel && penable);
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  ////////////////////////////////////////
  // saturates so a long run cannot wrap
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      cyc_q <= 0;
    else if (cyc_q < 99999)
      cyc_q <= cyc_q + 1;
  ////////////////////////////////////////
  a_one_wait: assert property (s_access |=> s_answer)
    else $error("pready not one cycle after access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fetch_junk: assert property (
    otp_fetch_block && $past(otp_fetch_block) && $past(otp_fetch_block, 2)
    |-> otp_rd_data == 8'(~$past(otp_rd_addr)))
    else $error("otp read not scrambled while latched");
  a_stop_clear: assert property ($rose(stop_mode)
    |-> ##[1:2] (!otp_fetch_block && !charge_pump_on))
    else $error("stop did not clear latches");
  a_pd_b_input: assert property ((port_b_pulldown & $past(port_b_ddr)) == 8'h00)
    else $error("port b pull-down on output pin");
  a_pd_c_input: assert property ((port_c_pulldown & $past(port_c_ddr)) == 8'h00)
    else $error("port c pull-down on output pin");
  a_erase_pump: assert property (ee_erase_cmd |-> charge_pump_on)
    else $error("erase without pump");
  a_pump_no_pass: assert property (charge_pump_on |-> !ee_wr_pass)
    else $error("plain write passed while pumping");
  a_hold_low: assert property (cyc_q < POR_LONG |-> !reset_pin_n)
    else $error("reset pin released early");
  a_hold_end: assert property (cyc_q == POR_LONG + 3 |-> reset_pin_n)
    else $error("reset pin held too long");
endmodule

bind nvm_program_control nvm_program_control_monitor #(.POR_LONG(POR_LONG)) mon_i (
  .ref_clk, .rst, .psel, .penable, .pready, .pslverr, .otp_rd_addr, .otp_rd_data,
  .otp_fetch_block, .stop_mode, .port_b_ddr, .port_c_ddr, .port_b_pulldown,
  .port_c_pulldown, .charge_pump_on, .ee_erase_cmd, .ee_wr_pass, .reset_pin_n
);

// file: dv/cpu_mem_model.sv
`timescale 1ns/1ns
module cpu_mem_model (
  input  wire logic        ref_clk,
  output nvm_pkg::mem_wr_t otp_wr,
  output nvm_pkg::mem_wr_t ee_wr,
  output logic [15:0]      otp_rd_addr
);
  initial
  begin
    otp_wr = '0;
    ee_wr = '0;
    otp_rd_addr = 16'h0000;
  end
  ////////////////////////////////////////
  // callers keep one group inside one eight-byte block
  // released fields carry the inverse, never stale data
  task automatic store(input logic ee, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    if (ee)
      ee_wr <= '{1'b1, a, d};
    else
      otp_wr <= '{1'b1, a, d};
    @(posedge ref_clk);
    if (ee)
      ee_wr <= '{1'b0, ~a, ~d};
    else
      otp_wr <= '{1'b0, ~a, ~d};
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge ref_clk);
    otp_rd_addr <= a;
  endtask
endmodule

// file: dv/tb_nvm_program_control.sv
`timescale 1ns/1ns
module tb_nvm_program_control;
  localparam logic [31:0] CA = 32'(nvm_pkg::CTRL_ADDR);
  localparam logic [31:0] OA = 32'(nvm_pkg::OPT_ADDR);
  localparam logic [31:0] FA = 32'(nvm_pkg::FACT_ADDR);
  localparam logic [31:0] SA = 32'(nvm_pkg::STAT_ADDR);
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [31:0]      paddr = 32'h0;
  logic [31:0]      pwdata = 32'h0;
  logic             stop_mode = 1'b0;
  logic             wait_mode = 1'b0;
  logic             bootstrap_mode = 1'b0;
  logic [7:0]       port_b_ddr = 8'h00;
  logic [7:0]       port_c_ddr = 8'h00;
  logic [31:0]      prdata;
  logic             pready, pslverr, otp_fetch_block, ee_wr_pass, watchdog_run;
  logic             non_user_block, charge_pump_on, ee_erase_cmd, ee_write_fail;
  logic             reset_pin_n;
  logic [7:0]       otp_rd_data, port_b_pulldown, port_c_pulldown;
  logic [15:0]      otp_rd_addr;
  nvm_pkg::mem_wr_t otp_wr, ee_wr;
  logic [32:0]      exq[$];
  logic [32:0]      e;
  int               mismatches = 0;
  int               compares = 0;
  int               seed = 39558;
  int               n, i;

  always #5 ref_clk = ~ref_clk;

  nvm_program_control #(.POR_LONG(40)) nvm_program_control_i (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .otp_wr, .otp_rd_addr, .otp_rd_data, .otp_fetch_block, .ee_wr, .ee_wr_pass,
    .stop_mode, .wait_mode, .bootstrap_mode, .port_b_ddr, .port_c_ddr, .port_b_pulldown,
    .port_c_pulldown, .watchdog_run, .non_user_block, .charge_pump_on, .ee_erase_cmd,
    .ee_write_fail, .external_clock_output_enable(), .reset_pin_n
  );
  cpu_mem_model cpu_mem_model_i (.ref_clk, .otp_wr, .ee_wr, .otp_rd_addr);
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [32:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // expectation is queued first; the watcher below compares at the answer
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] ex);
    int k;
    exq.push_back(ex);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      mismatches++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] ex);
    apb(1'b0, a, 32'h0, ex);
  endtask
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && exq.size() > 0)
    begin
      e = exq.pop_front();
      check("apb", {pslverr, pwrite ? 32'h0 : prdata}, e);
    end
  ////////////////////////////////////////
  initial
  begin
    tick(12);
    rst <= 1'b0;
    #1 check("rstpin", 33'(reset_pin_n), 33'h0);
    check("wdog", 33'(watchdog_run), 33'h0);
    check("nonuser", 33'(non_user_block), 33'h0);
    rd(CA, 33'h0);
    rd(OA, 33'h3);
    rd(FA, 33'h0);
    rd(32'h10, 33'h1_0000_0000);
    for (n = 0; n < 80 && reset_pin_n !== 1'b1; n++)
      tick(1);
    check("rstpin", 33'(reset_pin_n), 33'h1);
    $display("reset test done");
    wr(CA, 32'h10);
    rd(CA, 33'h0);
    wr(CA, 32'h20);
    rd(CA, 33'h20);
    check("fetch", 33'(otp_fetch_block), 33'h1);
    wr(CA, 32'h30);
    rd(CA, 33'h20);
    wr(FA, 32'h1F);
    rd(FA, 33'h1F);
    cpu_mem_model_i.store(1'b0, 16'h2008, 8'hA5);
    cpu_mem_model_i.store(1'b0, 16'h200F, 8'h5A);
    rd(SA, 33'h81);
    wr(CA, 32'h30);
    rd(CA, 33'h30);
    wr(CA, 32'h20);
    rd(CA, 33'h30);
    wr(CA, 32'h00);
    rd(CA, 33'h0);
    cpu_mem_model_i.fetch(16'h3000);
    tick(2);
    check("otprd", 33'(otp_rd_data), 33'h0);
    cpu_mem_model_i.fetch(16'h2008);
    tick(2);
    check("otprd", 33'(otp_rd_data), 33'hA5);
    $display("otp test done");
    for (i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      port_b_ddr <= 8'($random(seed));
      port_c_ddr <= 8'($random(seed));
      wait_mode <= 1'($random(seed));
      tick(2);
      check("pdb", 33'(port_b_pulldown), {25'h0, ~port_b_ddr});
      check("pdc", 33'(port_c_pulldown), {25'h0, ~port_c_ddr});
      check("wdog", 33'(watchdog_run), 33'h1);
    end
    $display("pull-down test done");
    wr(CA, 32'h03);
    rd(CA, 33'h02);
    cpu_mem_model_i.store(1'b1, 16'h0110, 8'h3C);
    wr(CA, 32'h03);
    rd(CA, 33'h03);
    check("pump", 33'(charge_pump_on), 33'h1);
    wr(CA, 32'h07);
    rd(CA, 33'h03);
    wr(CA, 32'h02);
    rd(CA, 33'h03);
    wr(CA, 32'h00);
    rd(CA, 33'h0);
    check("pump", 33'(charge_pump_on), 33'h0);
    wr(CA, 32'h06);
    rd(CA, 33'h06);
    cpu_mem_model_i.store(1'b1, 16'h0111, 8'h00);
    wr(CA, 32'h07);
    rd(CA, 33'h07);
    check("erase", 33'(ee_erase_cmd), 33'h1);
    wr(CA, 32'h27);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    tick(3);
    stop_mode <= 1'b0;
    rd(CA, 33'h0);
    check("fetch", 33'(otp_fetch_block), 33'h0);
    $display("eeprom test done");
    wr(OA, 32'h1);
    rd(OA, 33'h3);
    wr(CA, 32'h02);
    wr(OA, 32'h1);
    rd(OA, 33'h1);
    cpu_mem_model_i.store(1'b1, 16'h0150, 8'h00);
    wr(CA, 32'h03);
    tick(2);
    check("fail", 33'(ee_write_fail), 33'h1);
    check("pump", 33'(charge_pump_on), 33'h0);
    bootstrap_mode <= 1'b1;
    tick(2);
    check("pump", 33'(charge_pump_on), 33'h1);
    wr(CA, 32'h00);
    cpu_mem_model_i.store(1'b1, 16'h0105, 8'h11);
    #1 check("pass", 33'(ee_wr_pass), 33'h1);
    $display("protect test done");
    test_done();
  end
endmodule
